// File: rtl/mrca_top.sv
// Read side of the memory function command layer: plain memory read and
// memory-plus-counter read with per-page counter, zero bits and CRC trailer.
// Assumes an outside slot layer that turns master write slots into bit
// strobes, read slots into slot strobes, and reset pulses into one pulse;
// the memory array answers mem_data_in combinationally from mem_addr_out.
`timescale 1ns/1ns
`default_nettype none
module mrca_top
  import mrca_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int FIFO_DEPTH = MRCA_FIFO_DEPTH
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic func_start_in,
  input wire logic bus_reset_in,
  input wire logic wr_slot_in,
  input wire logic wr_bit_in,
  input wire logic rd_slot_in,
  output logic rd_bit_out,
  output logic [15:0] mem_addr_out,
  input wire logic [7:0] mem_data_in,
  input wire logic [mrca_pkg::MRCA_NUM_CNT_MAX-1:0][mrca_pkg::MRCA_CNT_WIDTH-1:0] counter_value_in,
  input wire logic es_load_in,
  input wire logic [7:0] es_value_in,
  output logic [15:0] target_addr_out,
  output logic [7:0] ending_status_out,
  output logic busy_out
);
  localparam int PAGES = LARGE_VARIANT ? MRCA_PAGES_LARGE : MRCA_PAGES_SMALL;
  localparam int FIRST_CNT = LARGE_VARIANT ? MRCA_FIRST_CNT_PAGE_LARGE : MRCA_FIRST_CNT_PAGE_SMALL;
  localparam int NUM_CNT = LARGE_VARIANT ? MRCA_NUM_CNT_LARGE : MRCA_NUM_CNT_SMALL;
  localparam logic [16:0] MEM_BYTES = 17'(PAGES << MRCA_PAGE_SHIFT);
  localparam logic [10:0] FIRST_CNT_PAGE = 11'(FIRST_CNT);
  localparam logic [10:0] NUM_CNT_PAGES = 11'(NUM_CNT);

  generate
    if (FIFO_DEPTH < 2)
    begin : g_bad_depth
      $error("mrca_top: FIFO_DEPTH must be at least 2");
    end
  endgenerate

  typedef struct packed {
    mrca_state_t state;
    mrca_phase_t phase;
    logic counter_mode;
    logic [7:0] rx_shift;
    logic [2:0] rx_count;
    logic [7:0] target_addr_low_byte;
    logic [7:0] target_addr_high_byte;
    logic [7:0] es;
    logic [15:0] addr;
    logic [1:0] idx;
    logic [31:0] cnt_latch;
    logic [7:0] tx_byte;
    logic [3:0] tx_bits;
    logic read_bit;
  } mrca_top_state_t;

  mrca_top_state_t s;
  mrca_top_state_t next_s;

  logic [7:0] rx_byte;
  logic rx_done;
  logic addr_in_range;
  logic [10:0] page_idx;
  logic [10:0] cnt_idx;
  logic [31:0] page_count;
  logic push_valid;
  logic [7:0] push_byte;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic fifo_flush;
  logic crc_clear;
  logic crc_valid;
  logic [7:0] crc_byte;
  logic [15:0] crc_value;

  // Byte assembly from write slots, LSB first
  assign rx_byte = {wr_bit_in, s.rx_shift[7:1]};
  assign rx_done = wr_slot_in && (s.rx_count == MRCA_RX_LAST_BIT);

  // Counter lookup for the page holding the current address
  assign addr_in_range = ({1'b0, s.addr} < MEM_BYTES);
  assign page_idx = s.addr[15:MRCA_PAGE_SHIFT];
  assign cnt_idx = page_idx - FIRST_CNT_PAGE;
  always_comb
  begin
    page_count = MRCA_NO_COUNTER;
    if (page_idx >= FIRST_CNT_PAGE && page_idx < FIRST_CNT_PAGE + NUM_CNT_PAGES)
    begin
      page_count = counter_value_in[cnt_idx[1:0]];
    end
  end

  // Command decoding, byte production and bit serialising
  always_comb
  begin
    next_s = s;
    push_valid = 1'b0;
    push_byte = MRCA_ONES_BYTE;
    fifo_pop = 1'b0;
    fifo_flush = 1'b0;
    crc_clear = 1'b0;
    crc_valid = 1'b0;
    crc_byte = rx_byte;
    if (es_load_in)
    begin
      next_s.es = es_value_in;
      next_s.es[MRCA_ES_ZERO_BIT] = 1'b0;
    end
    if (bus_reset_in)
    begin
      next_s.state = MRCA_ST_IDLE;
      next_s.phase = MRCA_PH_DATA;
      next_s.tx_bits = '0;
      next_s.rx_count = '0;
      fifo_flush = 1'b1;
      crc_clear = 1'b1;
    end
    else if (func_start_in)
    begin
      next_s.state = MRCA_ST_CMD;
      next_s.rx_count = '0;
      next_s.tx_bits = '0;
      fifo_flush = 1'b1;
      crc_clear = 1'b1;
    end
    else
    begin
      // Receive command and address bytes
      if (wr_slot_in && (s.state == MRCA_ST_CMD || s.state == MRCA_ST_ADDR_LO ||
          s.state == MRCA_ST_ADDR_HI))
      begin
        next_s.rx_shift = rx_byte;
        next_s.rx_count = s.rx_count + 3'h1;
      end
      if (rx_done)
      begin
        crc_valid = 1'b1;
        unique case (s.state)
          MRCA_ST_CMD:
          begin
            if (rx_byte == MRCA_CMD_READ_MEMORY)
            begin
              next_s.counter_mode = 1'b0;
              next_s.state = MRCA_ST_ADDR_LO;
            end
            else if (rx_byte == MRCA_CMD_READ_MEM_COUNTER)
            begin
              next_s.counter_mode = 1'b1;
              next_s.state = MRCA_ST_ADDR_LO;
            end
            else
            begin
              next_s.state = MRCA_ST_IGNORE;
            end
          end
          MRCA_ST_ADDR_LO:
          begin
            next_s.target_addr_low_byte = rx_byte;
            next_s.state = MRCA_ST_ADDR_HI;
          end
          MRCA_ST_ADDR_HI:
          begin
            next_s.target_addr_high_byte = rx_byte;
            next_s.addr = {rx_byte, s.target_addr_low_byte};
            next_s.state = MRCA_ST_STREAM;
            next_s.phase = MRCA_PH_DATA;
          end
          default:
          begin
            crc_valid = 1'b0;
          end
        endcase
      end
      // Produce outgoing bytes while the FIFO has room
      if (s.state == MRCA_ST_STREAM && fifo_in_ready)
      begin
        push_valid = 1'b1;
        crc_valid = s.counter_mode;
        unique case (s.phase)
          MRCA_PH_DATA:
          begin
            if (addr_in_range)
            begin
              push_byte = mem_data_in;
              next_s.addr = s.addr + 16'h0001;
              if (s.counter_mode && s.addr[MRCA_PAGE_SHIFT-1:0] == MRCA_PAGE_LAST_OFFSET)
              begin
                next_s.cnt_latch = page_count;
                next_s.phase = MRCA_PH_CNT;
                next_s.idx = '0;
              end
            end
            else if (s.counter_mode)
            begin
              push_valid = 1'b0;
              crc_valid = 1'b0;
              next_s.phase = MRCA_PH_ONES;
            end
          end
          MRCA_PH_CNT:
          begin
            push_byte = s.cnt_latch[7:0];
            next_s.cnt_latch = s.cnt_latch >> 8;
            next_s.idx = s.idx + 2'h1;
            if (s.idx == MRCA_TRAILER_LAST_IDX)
            begin
              next_s.phase = MRCA_PH_ZERO;
            end
          end
          MRCA_PH_ZERO:
          begin
            push_byte = MRCA_ZERO_BYTE;
            next_s.idx = s.idx + 2'h1;
            if (s.idx == MRCA_TRAILER_LAST_IDX)
            begin
              next_s.phase = MRCA_PH_CRCL;
            end
          end
          MRCA_PH_CRCL:
          begin
            crc_valid = 1'b0;
            push_byte = ~crc_value[7:0];
            next_s.phase = MRCA_PH_CRCH;
          end
          MRCA_PH_CRCH:
          begin
            crc_valid = 1'b0;
            crc_clear = 1'b1;
            push_byte = ~crc_value[15:8];
            next_s.phase = addr_in_range ? MRCA_PH_DATA : MRCA_PH_ONES;
          end
          MRCA_PH_ONES:
          begin
            crc_valid = 1'b0;
            push_byte = MRCA_ONES_BYTE;
          end
          default:
          begin
            push_valid = 1'b0;
            crc_valid = 1'b0;
            next_s.phase = MRCA_PH_ONES;
          end
        endcase
        if (crc_valid)
        begin
          crc_byte = push_byte;
        end
      end
      // Serialiser: shift out one bit per read slot, LSB first
      if (s.tx_bits == '0)
      begin
        fifo_pop = fifo_out_valid;
        if (fifo_out_valid)
        begin
          next_s.tx_byte = fifo_out_data;
          next_s.tx_bits = MRCA_TX_FULL_BITS;
        end
      end
      else if (rd_slot_in)
      begin
        next_s.tx_byte = s.tx_byte >> 1;
        next_s.tx_bits = s.tx_bits - 4'h1;
      end
    end
    // Idle line reads as ones when no byte is loaded
    next_s.read_bit = (next_s.tx_bits != '0) ? next_s.tx_byte[0] : 1'b1;
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s <= '{state: MRCA_ST_IDLE, phase: MRCA_PH_DATA, counter_mode: 1'b0,
             rx_shift: 8'h00, rx_count: 3'h0,
             target_addr_low_byte: MRCA_TA_RESET[7:0],
             target_addr_high_byte: MRCA_TA_RESET[15:8], es: MRCA_ES_RESET,
             addr: 16'h0000, idx: 2'h0, cnt_latch: 32'h0000_0000,
             tx_byte: MRCA_ONES_BYTE, tx_bits: 4'h0, read_bit: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outgoing byte buffer between producer and serialiser
  mrca_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .flush_in(fifo_flush),
    .in_valid_in(push_valid),
    .in_data_in(push_byte),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(fifo_out_valid),
    .out_data_out(fifo_out_data),
    .out_ready_in(fifo_pop)
  );

  // CRC over received bytes and, in counter mode only, produced data and trailer bytes
  mrca_crc16 u_crc (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clear_in(crc_clear),
    .valid_in(crc_valid),
    .byte_in(crc_byte),
    .crc_out(crc_value)
  );

  // Register-backed outputs
  assign rd_bit_out = s.read_bit;
  assign mem_addr_out = s.addr;
  assign target_addr_out = {s.target_addr_high_byte, s.target_addr_low_byte};
  assign ending_status_out = s.es;
  assign busy_out = (s.state != MRCA_ST_IDLE);
endmodule : mrca_top
`default_nettype wire

// File: include/mrca_pkg.sv
// Constants and enumerations for the memory read / counter access block.
// Assumes the serial slot layer and the memory array sit outside this block.
`default_nettype none
package mrca_pkg;
  // Memory function command codes
  localparam logic [7:0] MRCA_CMD_READ_MEMORY = 8'hF0;
  localparam logic [7:0] MRCA_CMD_READ_MEM_COUNTER = 8'hA5;
  // Page geometry
  localparam int MRCA_PAGE_SHIFT = 5;
  localparam logic [4:0] MRCA_PAGE_LAST_OFFSET = 5'h1F;
  localparam int MRCA_PAGES_LARGE = 16;
  localparam int MRCA_PAGES_SMALL = 4;
  // Counter-to-page mapping
  localparam int MRCA_FIRST_CNT_PAGE_LARGE = 12;
  localparam int MRCA_FIRST_CNT_PAGE_SMALL = 1;
  localparam int MRCA_NUM_CNT_LARGE = 4;
  localparam int MRCA_NUM_CNT_SMALL = 3;
  localparam int MRCA_NUM_CNT_MAX = 4;
  localparam int MRCA_CNT_WIDTH = 32;
  localparam logic [1:0] MRCA_TRAILER_LAST_IDX = 2'h3;
  // Fill values
  localparam logic [7:0] MRCA_ONES_BYTE = 8'hFF;
  localparam logic [7:0] MRCA_ZERO_BYTE = 8'h00;
  localparam logic [31:0] MRCA_NO_COUNTER = 32'hFFFF_FFFF;
  // Ending offset / status byte layout
  localparam int MRCA_ES_AUTH_BIT = 7;
  localparam int MRCA_ES_ZERO_BIT = 6;
  localparam int MRCA_ES_PARTIAL_BIT = 5;
  localparam int MRCA_ES_OFFSET_MSB = 4;
  localparam logic [7:0] MRCA_ES_RESET = 8'h00;
  localparam logic [15:0] MRCA_TA_RESET = 16'h0000;
  // Bit-reversed CRC16 polynomial, bits shifted in LSB first
  localparam logic [15:0] MRCA_CRC_POLY_REFLECTED = 16'hA001;
  localparam logic [15:0] MRCA_CRC_RESET = 16'h0000;
  // Byte receive and transmit bit counts, FIFO depth
  localparam logic [2:0] MRCA_RX_LAST_BIT = 3'h7;
  localparam logic [3:0] MRCA_TX_FULL_BITS = 4'h8;
  localparam int MRCA_FIFO_DEPTH = 16;

  typedef enum logic [5:0] {
    MRCA_ST_IDLE = 6'h01,
    MRCA_ST_CMD = 6'h02,
    MRCA_ST_ADDR_LO = 6'h04,
    MRCA_ST_ADDR_HI = 6'h08,
    MRCA_ST_STREAM = 6'h10,
    MRCA_ST_IGNORE = 6'h20
  } mrca_state_t;

  typedef enum logic [5:0] {
    MRCA_PH_DATA = 6'h01,
    MRCA_PH_CNT = 6'h02,
    MRCA_PH_ZERO = 6'h04,
    MRCA_PH_CRCL = 6'h08,
    MRCA_PH_CRCH = 6'h10,
    MRCA_PH_ONES = 6'h20
  } mrca_phase_t;
endpackage : mrca_pkg
`default_nettype wire

// File: rtl/mrca_crc16.sv
// Serial CRC16 generator, fed one byte per cycle, bits taken LSB first.
// Assumes clear and byte strobes come from the command logic of the block.
`timescale 1ns/1ns
`default_nettype none
module mrca_crc16
  import mrca_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clear_in,
  input wire logic valid_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);
  typedef struct packed {
    logic [15:0] crc;
  } mrca_crc_state_t;

  mrca_crc_state_t s;
  mrca_crc_state_t next_s;

  // Clear wins; otherwise shift eight bits in transmit order
  always_comb
  begin
    logic [15:0] c;
    c = s.crc;
    next_s = s;
    if (clear_in)
    begin
      next_s.crc = MRCA_CRC_RESET;
    end
    else if (valid_in)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (c[0] ^ byte_in[i])
        begin
          c = (c >> 1) ^ MRCA_CRC_POLY_REFLECTED;
        end
        else
        begin
          c = c >> 1;
        end
      end
      next_s.crc = c;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s <= '{crc: MRCA_CRC_RESET};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign crc_out = s.crc;
endmodule : mrca_crc16
`default_nettype wire

// File: rtl/mrca_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock; DEPTH must be a power of two.
`timescale 1ns/1ns
`default_nettype none
module mrca_fifo
  import mrca_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = MRCA_FIFO_DEPTH
)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
    begin : g_bad_param
      $error("mrca_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } mrca_fifo_state_t;

  mrca_fifo_state_t s;
  mrca_fifo_state_t next_s;
  logic full;
  logic empty;

  // Pointers carry one extra wrap bit to tell full from empty
  assign empty = (s.wr_ptr == s.rd_ptr);
  assign full = (s.wr_ptr[AW-1:0] == s.rd_ptr[AW-1:0]) && (s.wr_ptr[AW] != s.rd_ptr[AW]);
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = s.mem[s.rd_ptr[AW-1:0]];

  // Push, pop and flush
  always_comb
  begin
    next_s = s;
    if (flush_in)
    begin
      next_s.wr_ptr = '0;
      next_s.rd_ptr = '0;
    end
    else
    begin
      if (in_valid_in && !full)
      begin
        next_s.mem[s.wr_ptr[AW-1:0]] = in_data_in;
        next_s.wr_ptr = s.wr_ptr + 1'b1;
      end
      if (out_ready_in && !empty)
      begin
        next_s.rd_ptr = s.rd_ptr + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : mrca_fifo
`default_nettype wire

// File: testbench/mrca_checker.sv
// Checker bound to the read/counter access top: status, address and abandon behaviour.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module mrca_checker
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic func_start_in,
  input wire logic bus_reset_in,
  input wire logic es_load_in,
  input wire logic [7:0] es_value_in,
  input wire logic rd_bit_out,
  input wire logic [15:0] mem_addr_out,
  input wire logic [15:0] target_addr_out,
  input wire logic [7:0] ending_status_out,
  input wire logic busy_out
);
  logic [7:0] es_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // Status value offered one cycle earlier
  always_ff @(posedge clk_in)
    es_q <= es_value_in;
  // Status byte layout and update
  property p_bit6_zero;
    ending_status_out[6] == 1'b0;
  endproperty
  a_bit6_zero: assert property (p_bit6_zero) else $error("status bit 6 set");
  property p_es_load;
    es_load_in |=> ending_status_out == {es_q[7], 1'b0, es_q[5:0]};
  endproperty
  a_es_load: assert property (p_es_load) else $error("status load wrong");
  property p_es_stable;
    !es_load_in |=> $stable(ending_status_out);
  endproperty
  a_es_stable: assert property (p_es_stable) else $error("status changed");
  // Address registers move only inside a command
  property p_ta_idle;
    !busy_out |=> $stable(target_addr_out);
  endproperty
  a_ta_idle: assert property (p_ta_idle) else $error("target moved while idle");
  // Low byte lands one address byte (16 cycles) before the read pointer follows
  property p_addr_follow;
    $changed(target_addr_out) |-> ##[0:20] (mem_addr_out == target_addr_out);
  endproperty
  a_addr_follow: assert property (p_addr_follow) else $error("read not at target");
  // Command start and abandon
  property p_start_busy;
    func_start_in && !bus_reset_in |=> busy_out;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");
  property p_bus_reset;
    bus_reset_in |-> ##[1:2] (!busy_out && rd_bit_out);
  endproperty
  a_bus_reset: assert property (p_bus_reset) else $error("sequence not abandoned");
  property p_idle_ones;
    !busy_out && !$past(busy_out) |-> rd_bit_out;
  endproperty
  a_idle_ones: assert property (p_idle_ones) else $error("idle bit not one");
  // Main scenarios reached
  c_es_load: cover property (es_load_in);
  c_abandon: cover property (bus_reset_in && busy_out);
  c_addr: cover property ($changed(target_addr_out));
endmodule : mrca_checker
bind mrca_top mrca_checker mrca_checker_inst (.clk_in, .nrst_in, .func_start_in, .bus_reset_in,
  .es_load_in, .es_value_in, .rd_bit_out, .mem_addr_out, .target_addr_out, .ending_status_out,
  .busy_out);
`default_nettype wire

// File: testbench/mrca_master_model.sv
// Bus master stand-in: command strobes, write slots and read slots toward the top.
// Assumes the slot layer already turned line timing into one-cycle strobes.
`timescale 1ns/1ns
`default_nettype none
module mrca_master_model
(
  input wire logic clk_in,
  input wire logic rd_bit_in,
  output logic func_start_out,
  output logic bus_reset_out,
  output logic wr_slot_out,
  output logic wr_bit_out,
  output logic rd_slot_out
);
  // Quiet strobes from time zero
  initial
  begin
    func_start_out = 1'b0;
    bus_reset_out = 1'b0;
    wr_slot_out = 1'b0;
    wr_bit_out = 1'b1;
    rd_slot_out = 1'b0;
  end
  // One-cycle command start or reset pulse
  task automatic strobe(input logic rst);
    @(posedge clk_in) #1 func_start_out = ~rst;
    bus_reset_out = rst;
    @(posedge clk_in) #1 func_start_out = 1'b0;
    bus_reset_out = 1'b0;
  endtask : strobe
  // Write slots, LSB first; the bit line flips once a slot is over
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in) #1 wr_bit_out = b[i];
      wr_slot_out = 1'b1;
      @(posedge clk_in) #1 wr_slot_out = 1'b0;
      wr_bit_out = ~b[i];
    end
  endtask : send_byte
  // Read slots four cycles apart, bits gathered LSB first
  task automatic read_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_in) #1 b[i] = rd_bit_in;
      rd_slot_out = 1'b1;
      @(posedge clk_in) #1 rd_slot_out = 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask : read_byte
endmodule : mrca_master_model
`default_nettype wire

// File: testbench/tb_memory_read_counter_access.sv
// Self-checking bench for the read/counter access top with a master stand-in.
// Assumes memory answers combinationally and counters hold random values.
`timescale 1ns/1ns
`default_nettype none
module tb_memory_read_counter_access;
  import mrca_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic es_load_in;
  logic [7:0] es_value_in;
  logic [3:0][31:0] cnt;
  logic func_start, bus_reset, wr_slot, wr_bit, rd_slot, rd_bit, busy;
  logic [15:0] mem_addr, target_addr, crc, a;
  logic [7:0] mem_data, es_exp, b, status;
  logic [7:0] q[$];
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  // Memory contents derived from the address
  function automatic logic [7:0] mem_byte(input logic [15:0] x);
    return x[7:0] ^ {x[8], 7'h35};
  endfunction : mem_byte
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'hA001 : c >> 1;
    return c;
  endfunction : crc_upd
  assign mem_data = mem_byte(mem_addr);
  always #25 clk_in = ~clk_in;
  mrca_top mrca_top_inst (.clk_in(clk_in),
    .nrst_in(nrst_in), .func_start_in(func_start), .bus_reset_in(bus_reset),
    .wr_slot_in(wr_slot), .wr_bit_in(wr_bit), .rd_slot_in(rd_slot), .rd_bit_out(rd_bit),
    .mem_addr_out(mem_addr), .mem_data_in(mem_data), .counter_value_in(cnt),
    .es_load_in(es_load_in), .es_value_in(es_value_in), .target_addr_out(target_addr),
    .ending_status_out(status), .busy_out(busy));
  mrca_master_model mrca_master_model_inst (.clk_in(clk_in), .rd_bit_in(rd_bit),
    .func_start_out(func_start), .bus_reset_out(bus_reset), .wr_slot_out(wr_slot),
    .wr_bit_out(wr_bit), .rd_slot_out(rd_slot));
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Register compare, bytes compare through it
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({8'h00, got}, {8'h00, exp});
  endtask : chk_byte
  task automatic add(input logic [7:0] d);
    q.push_back(d);
    crc = crc_upd(crc, d);
  endtask : add
  // Expected counter-mode stream: page data, counter, zeros, inverted CRC
  task automatic build_cnt(input logic [15:0] st);
    logic [31:0] c;
    q.delete();
    crc = crc_upd(crc_upd(crc_upd(16'h0000, 8'hA5), st[7:0]), st[15:8]);
    for (int p = st[15:5]; p < 16; p++)
    begin
      for (int x = (p == st[15:5]) ? st : p * 32; x < p * 32 + 32; x++)
        add(mem_byte(16'(x)));
      c = (p >= 12) ? cnt[p - 12] : 32'hFFFF_FFFF;
      for (int x = 0; x < 8; x++)
        add((x < 4) ? c[x * 8 +: 8] : 8'h00);
      c[15:0] = ~crc;
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      crc = 16'h0000;
    end
    repeat (3) q.push_back(8'hFF);
  endtask : build_cnt
  task automatic open_cmd(input logic [7:0] cmd, input logic [15:0] ad);
    mrca_master_model_inst.strobe(1'b0);
    mrca_master_model_inst.send_byte(cmd);
    mrca_master_model_inst.send_byte(ad[7:0]);
    mrca_master_model_inst.send_byte(ad[15:8]);
    repeat (6) @(posedge clk_in);
  endtask : open_cmd
  task automatic read_cmp(input int n);
    logic [7:0] r;
    repeat (n)
    begin
      mrca_master_model_inst.read_byte(r);
      chk_byte(r, q.pop_front());
    end
  endtask : read_cmp
  // Cycle ceiling against hangs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      final_report();
    end
  end
  // Test sequence
  initial
  begin
    void'($urandom(32'hcdd8_de6d));
    es_load_in = 1'b0;
    es_value_in = 8'h00;
    cnt = {$urandom(), $urandom(), $urandom(), $urandom()};
    repeat (10) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    // Bit 6 offered set so that its forced clearing is seen
    @(posedge clk_in) #1 es_value_in = 8'($urandom()) | 8'h40;
    es_load_in = 1'b1;
    @(posedge clk_in) #1 es_load_in = 1'b0;
    es_exp = {es_value_in[7], 1'b0, es_value_in[5:0]};
    @(posedge clk_in) #1 chk_reg({8'h00, status}, {8'h00, es_exp});
    $display("test status load done");
    a = 16'h01F0 + 16'($urandom_range(15));
    open_cmd(8'hF0, a);
    chk_reg(target_addr, a);
    for (int i = 0; i < 20; i++)
    begin
      mrca_master_model_inst.read_byte(b);
      chk_byte(b, (a + i < 512) ? mem_byte(16'(a + i)) : 8'hFF);
    end
    chk_reg({8'h00, status}, {8'h00, es_exp});
    mrca_master_model_inst.strobe(1'b1);
    $display("test plain read done");
    a = 16'h01C0;
    build_cnt(a);
    open_cmd(8'hA5, a);
    read_cmp(87);
    mrca_master_model_inst.strobe(1'b1);
    $display("test counter read to end done");
    a = 16'($urandom_range(31));
    build_cnt(a);
    open_cmd(8'hA5, a);
    read_cmp(45 - int'(a));
    mrca_master_model_inst.strobe(1'b1);
    repeat (3) @(posedge clk_in);
    chk_reg({15'h0000, busy}, 16'h0000);
    mrca_master_model_inst.read_byte(b);
    chk_byte(b, 8'hFF);
    $display("test counter read abandon done");
    open_cmd(8'h3C, 16'h0042);
    mrca_master_model_inst.read_byte(b);
    chk_byte(b, 8'hFF);
    chk_reg(target_addr, a);
    $display("test unknown command done");
    final_report();
  end
endmodule : tb_memory_read_counter_access
`default_nettype wire
